// *** common/msbu_defs.svh ***
/*
 * Constants for the microprogram sequencer: widths, reset values and the
 * interrupt entry address.
 * Assumes inclusion by bare name from every file that needs the figures.
 */
`ifndef MSBU_DEFS_SVH
`define MSBU_DEFS_SVH

// ==========================================================================
// widths
`define MSBU_PTR_W 12
`define MSBU_XBAR_W 16
`define MSBU_STK_DEPTH 16
`define MSBU_STK_AW 4
`define MSBU_NCLK 5
`define MSBU_NCOND 4
`define MSBU_NCCLK 8
`define MSBU_NPORT 8

// ==========================================================================
// clock bit positions within the per-instruction clock field
`define MSBU_CLK_LATCH 0
`define MSBU_CLK_PUSH 1
`define MSBU_CLK_POP 2
`define MSBU_CLK_INH_JUMP 3
`define MSBU_CLK_INH_FALL 4

// ==========================================================================
// reset values, stack top address and interrupt entry address
`define MSBU_PTR_RST 12'h000
`define MSBU_STK_ADDR_RST 4'h0
`define MSBU_STK_ADDR_TOP 4'hf
`define MSBU_IRQ_VECTOR 12'h001

`endif

// *** common/msbu_pkg.sv ***
/*
 * Types for the microprogram sequencer: source encodings and the packed
 * instruction and saved-state carriers.
 * Assumes msbu_defs.svh is on the include path.
 */
`include "msbu_defs.svh"

package msbu_pkg;

  // ==========================================================================
  // jump target sources
  typedef enum logic [2:0] {
    JMP_STACK = 3'b000,
    JMP_PTR_K = 3'b001,
    JMP_K_OPND = 3'b010,
    JMP_K = 3'b011,
    JMP_STACK_OPND = 3'b100,
    JMP_PTR_OPND = 3'b101,
    JMP_OPND_X2 = 3'b110,
    JMP_OPND = 3'b111
  } jump_src_e;

  // stack write sources; code 3'b111 writes nothing
  typedef enum logic [2:0] {
    STK_PTR_K = 3'b000,
    STK_K_OPND = 3'b001,
    STK_K = 3'b010,
    STK_TOP_OPND = 3'b011,
    STK_PTR_OPND = 3'b100,
    STK_OPND_X2 = 3'b101,
    STK_OPND = 3'b110,
    STK_NONE = 3'b111
  } stack_src_e;

  // ==========================================================================
  // one microinstruction as seen by the sequencer
  typedef struct packed {
    logic [`MSBU_NCLK-1:0] clkBits;
    logic jumpEn;
    jump_src_e jumpSrc;
    logic [`MSBU_NCOND-1:0] condMask;
    logic stackWrite;
    stack_src_e stackSrc;
    logic stackClear;
    logic [`MSBU_PTR_W-1:0] constant;
    logic condClkEn;
    logic [2:0] unitSelectField;
  } instr_s;

  // state kept across an interrupt
  typedef struct packed {
    logic [`MSBU_PTR_W-1:0] ptr;
    logic [`MSBU_STK_AW-1:0] stackAddress;
    logic [`MSBU_XBAR_W-1:0] operand;
    logic [`MSBU_XBAR_W-1:0] machState;
  } saved_state_s;

endpackage

// *** hdl/microsequencer_branch_unit.sv ***
/*
 * Microprogram sequencer and branch unit: instruction pointer, return
 * stack, jump and stack target arithmetic, inhibit of the following
 * instruction, conditional unit clocks, single-level interrupts with
 * state save and restore, pending and overflow status.
 * Assumes every input but resetn is synchronous to sys_clk and that one instruction
 * is presented per cycle while instrValid is high.
 */
`include "msbu_defs.svh"

module microsequencer_branch_unit
  import msbu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // microinstruction and operands
  input wire logic instrValid,
  input wire instr_s instr,
  input wire logic [`MSBU_XBAR_W-1:0] xbarIn,
  input wire logic [`MSBU_NCOND-1:0] conditions,
  // unit clock bits to be conditionally complemented
  input wire logic [`MSBU_NCCLK-1:0] unitClkIn,
  output logic [`MSBU_NCCLK-1:0] unitClkOut,
  // interrupt network
  input wire logic [`MSBU_NPORT-1:0] ringIrqReq,
  input wire logic [`MSBU_NPORT-1:0] portEnable,
  input wire logic irqActivate,
  input wire logic irqDeactivate,
  input wire logic irqReturn,
  input wire logic [`MSBU_XBAR_W-1:0] machStateIn,
  // ring port command
  input wire logic overflowClear,
  // sequencer state
  output logic [`MSBU_PTR_W-1:0] instrPtr,
  output logic [`MSBU_PTR_W-1:0] stackTop,
  output logic [`MSBU_STK_AW-1:0] stackAddress,
  output logic [`MSBU_XBAR_W-1:0] operandReg,
  output logic suppressNext,
  // saved state and restore
  output saved_state_s savedState,
  output logic restoreStrobe,
  output logic irqInService,
  // status
  output logic irqPending,
  output logic stackOverflow
);

  // ==========================================================================
  // functions

  // twelve-bit address sum, carry dropped on purpose
  function automatic logic [`MSBU_PTR_W-1:0] addr12(input logic [`MSBU_PTR_W-1:0] a,
                                                   input logic [`MSBU_PTR_W-1:0] b);
    logic [`MSBU_PTR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[`MSBU_PTR_W-1:0];
  endfunction

  // ==========================================================================
  // reset synchroniser

  logic rstMeta_q;
  logic rstn;

  // release through two flops; only the second one is used downstream
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstn <= rstMeta_q;
    end
  end

  // ==========================================================================
  // instruction decode

  logic exec;
  logic taken;
  logic [`MSBU_PTR_W-1:0] opnd;
  logic [`MSBU_PTR_W-1:0] k;
  logic [`MSBU_PTR_W-1:0] jumpTarget;
  logic [`MSBU_PTR_W-1:0] stackData;
  logic anyCond;
  logic irqTake;

  // a suppressed instruction still occupies its cycle but does nothing
  assign exec = instrValid && !suppressNext && !irqTake;
  assign opnd = operandReg[`MSBU_PTR_W-1:0];
  assign k = instr.constant;
  // empty mask means an unconditional jump
  assign anyCond = (instr.condMask == '0) || |(instr.condMask & conditions);
  assign taken = exec && instr.jumpEn && anyCond;

  // jump target selection
  always_comb begin
    case (instr.jumpSrc)
      JMP_STACK: jumpTarget = stackTop;
      JMP_PTR_K: jumpTarget = addr12(instrPtr, k);
      JMP_K_OPND: jumpTarget = addr12(k, opnd);
      JMP_K: jumpTarget = k;
      JMP_STACK_OPND: jumpTarget = addr12(stackTop, opnd);
      JMP_PTR_OPND: jumpTarget = addr12(instrPtr, opnd);
      JMP_OPND_X2: jumpTarget = addr12(opnd, opnd);
      JMP_OPND: jumpTarget = opnd;
      default: jumpTarget = opnd;
    endcase
  end

  // stack write data selection
  always_comb begin
    case (instr.stackSrc)
      STK_PTR_K: stackData = addr12(instrPtr, k);
      STK_K_OPND: stackData = addr12(k, opnd);
      STK_K: stackData = k;
      STK_TOP_OPND: stackData = addr12(stackTop, opnd);
      STK_PTR_OPND: stackData = addr12(instrPtr, opnd);
      STK_OPND_X2: stackData = addr12(opnd, opnd);
      STK_OPND: stackData = opnd;
      default: stackData = stackTop;
    endcase
  end

  // ==========================================================================
  // interrupt network

  logic [`MSBU_NPORT-1:0] enabledReq;
  logic irqActive_q;
  logic irqActive_d;
  logic irqInService_d;
  logic irqPending_d;
  logic restoreStrobe_d;
  saved_state_s savedState_d;
  logic irqExit;

  assign enabledReq = ringIrqReq & portEnable;
  // entry only at an instruction boundary so the saved pointer is exact
  assign irqTake = irqActive_q && !irqInService && |enabledReq && instrValid && !suppressNext;
  assign irqExit = irqInService && irqReturn;

  always_comb begin
    irqActive_d = irqActive_q;
    if (irqActivate) begin
      irqActive_d = 1'b1;
    end
    // deactivate wins when both arrive together
    if (irqDeactivate) begin
      irqActive_d = 1'b0;
    end
    irqInService_d = irqInService;
    if (irqTake) begin
      irqInService_d = 1'b1;
    end else if (irqExit) begin
      irqInService_d = 1'b0;
    end
    irqPending_d = |enabledReq && !irqInService_d;
    savedState_d = savedState;
    if (irqTake) begin
      savedState_d.ptr = instrPtr;
      savedState_d.stackAddress = stackAddress;
      savedState_d.operand = operandReg;
      savedState_d.machState = machStateIn;
    end
    restoreStrobe_d = irqExit;
  end

  // saved state stays on its port for the program and ring port to read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqActive_q <= 1'b0;
      irqInService <= 1'b0;
      irqPending <= 1'b0;
      savedState <= '0;
      restoreStrobe <= 1'b0;
    end else begin
      irqActive_q <= irqActive_d;
      irqInService <= irqInService_d;
      irqPending <= irqPending_d;
      savedState <= savedState_d;
      restoreStrobe <= restoreStrobe_d;
    end
  end

  // ==========================================================================
  // pointer, operand register, inhibit

  logic [`MSBU_PTR_W-1:0] instrPtr_d;
  logic [`MSBU_XBAR_W-1:0] operandReg_d;
  logic suppressNext_d;

  always_comb begin
    instrPtr_d = addr12(instrPtr, `MSBU_PTR_W'(1));
    if (irqTake) begin
      instrPtr_d = `MSBU_IRQ_VECTOR;
    end else if (irqExit) begin
      instrPtr_d = savedState.ptr;
    end else if (taken) begin
      instrPtr_d = jumpTarget;
    end else if (!instrValid) begin
      instrPtr_d = instrPtr;
    end
    operandReg_d = operandReg;
    if (irqExit) begin
      operandReg_d = savedState.operand;
    end else if (exec && instr.clkBits[`MSBU_CLK_LATCH]) begin
      operandReg_d = xbarIn;
    end
    suppressNext_d = 1'b0;
    if (exec) begin
      suppressNext_d = (instr.clkBits[`MSBU_CLK_INH_JUMP] && taken) ||
                       (instr.clkBits[`MSBU_CLK_INH_FALL] && !taken);
    end else if (!instrValid) begin
      suppressNext_d = suppressNext;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instrPtr <= `MSBU_PTR_RST;
      operandReg <= '0;
      suppressNext <= 1'b0;
    end else begin
      instrPtr <= instrPtr_d;
      operandReg <= operandReg_d;
      suppressNext <= suppressNext_d;
    end
  end

  // ==========================================================================
  // return stack

  logic [`MSBU_STK_AW-1:0] stackAddress_d;
  logic stackOverflow_d;
  logic stkWrEn;
  logic pushAtTop;

  assign pushAtTop = exec && instr.clkBits[`MSBU_CLK_PUSH] && stackAddress == `MSBU_STK_ADDR_TOP;
  // writes land on the new top, after any push or pop in the same instruction
  assign stkWrEn = exec && instr.stackWrite && instr.stackSrc != STK_NONE;

  always_comb begin
    stackAddress_d = stackAddress;
    if (irqExit) begin
      stackAddress_d = savedState.stackAddress;
    end else if (exec && instr.stackClear) begin
      stackAddress_d = `MSBU_STK_ADDR_RST;
    end else if (exec && instr.clkBits[`MSBU_CLK_PUSH] && !instr.clkBits[`MSBU_CLK_POP]) begin
      // saturate at the top so older entries are not overwritten silently
      if (!pushAtTop) begin
        stackAddress_d = stackAddress + `MSBU_STK_AW'(1);
      end
    end else if (exec && instr.clkBits[`MSBU_CLK_POP] && !instr.clkBits[`MSBU_CLK_PUSH]) begin
      stackAddress_d = stackAddress - `MSBU_STK_AW'(1);
    end
    stackOverflow_d = stackOverflow;
    if (overflowClear) begin
      stackOverflow_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (pushAtTop) begin
      stackOverflow_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stackAddress <= `MSBU_STK_ADDR_RST;
      stackOverflow <= 1'b0;
    end else begin
      stackAddress <= stackAddress_d;
      stackOverflow <= stackOverflow_d;
    end
  end

  // top of stack follows the next address through a registered read
  return_stack_mem stackMem (
    .clk(sys_clk),
    .rstn(rstn),
    .wrEn(stkWrEn),
    .wrAddr(stackAddress_d),
    .wrData(stackData),
    .rdAddr(stackAddress_d),
    .rdData(stackTop)
  );

  // ==========================================================================
  // conditional unit clocks

  logic [`MSBU_NCCLK-1:0] unitClkOut_d;
  logic [`MSBU_NCCLK-1:0] ccSel;

  // bit order: adder0 a/b, adder1 a/b, file f, file g, shift0, shift1
  always_comb begin
    ccSel = '0;
    if (exec && instr.condClkEn) begin
      ccSel[instr.unitSelectField] = 1'b1;
    end
    unitClkOut_d = unitClkIn;
    if (|(instr.condMask & conditions)) begin
      unitClkOut_d = unitClkIn ^ ccSel;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unitClkOut <= '0;
    end else begin
      unitClkOut <= unitClkOut_d;
    end
  end

endmodule // microsequencer_branch_unit

// *** hdl/return_stack_mem.sv ***
/*
 * Sixteen-word return stack storage with one write port and a registered
 * read port; a write to the address being read is seen at once.
 * Assumes a synchronous clock and the already synchronised reset.
 */
`include "msbu_defs.svh"

module return_stack_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic wrEn,
  input wire logic [`MSBU_STK_AW-1:0] wrAddr,
  input wire logic [`MSBU_PTR_W-1:0] wrData,
  // read port
  input wire logic [`MSBU_STK_AW-1:0] rdAddr,
  output logic [`MSBU_PTR_W-1:0] rdData
);

  logic [`MSBU_PTR_W-1:0] mem_q [`MSBU_STK_DEPTH];
  logic [`MSBU_PTR_W-1:0] rdData_d;

  // write-first so a fresh write is the top seen next cycle
  always_comb begin
    rdData_d = mem_q[rdAddr];
    if (wrEn && wrAddr == rdAddr) begin
      rdData_d = wrData;
    end
  end

  // storage array has no reset; only the read register does
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= `MSBU_PTR_RST;
    end else begin
      rdData <= rdData_d;
    end
  end

endmodule // return_stack_mem

// *** sim/microsequencer_branch_unit_properties.sv ***
/*
 * Port checker for the microprogram sequencer.
 * Assumes it is bound onto the sequencer top and sees only its ports.
 */
`include "msbu_defs.svh"

module microsequencer_branch_unit_properties
  import msbu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // instruction side
  input wire logic instrValid,
  input wire instr_s instr,
  input wire logic [3:0] conditions,
  input wire logic [7:0] unitClkIn,
  input wire logic [7:0] unitClkOut,
  // interrupt and ring side
  input wire logic [7:0] ringIrqReq,
  input wire logic [7:0] portEnable,
  input wire logic irqReturn,
  input wire logic overflowClear,
  // sequencer state and status
  input wire logic [11:0] instrPtr,
  input wire logic [3:0] stackAddress,
  input wire logic suppressNext,
  input wire saved_state_s savedState,
  input wire logic restoreStrobe,
  input wire logic irqInService,
  input wire logic irqPending,
  input wire logic stackOverflow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // helpers
  logic [2:0] live_q;
  logic live, calm, acc;
  logic [7:0] flipped;

  // internal reset copy lags the port by two edges, so wait three
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) live_q <= 3'h0;
    else live_q <= {live_q[1:0], 1'b1};
  end
  assign live = live_q[2];
  assign calm = ~|(ringIrqReq & portEnable) && !irqReturn;
  assign acc = live && instrValid && !suppressNext && calm;
  assign flipped = unitClkIn ^ ((instr.condClkEn && |(instr.condMask & conditions)) ?
                                8'h01 << instr.unitSelectField : 8'h00);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========================================
  // properties
  a_ptr_step: assert property (acc && !instr.jumpEn |=> instrPtr == $past(instrPtr) + 12'h001)
    else $error("pointer did not advance by one");
  a_jump_const: assert property (acc && instr.jumpEn && instr.condMask == 4'h0 && instr.jumpSrc == JMP_K
    |=> instrPtr == $past(instr.constant)) else $error("jump to constant missed");
  a_inhibit_jump: assert property (acc && instr.jumpEn && instr.condMask == 4'h0 && instr.clkBits[3]
    |=> suppressNext) else $error("no inhibit after taken jump");
  a_inhibit_fall: assert property (acc && !instr.jumpEn && instr.clkBits[4] |=> suppressNext)
    else $error("no inhibit after fall-through");
  a_inhibit_once: assert property (suppressNext && instrValid |=> !suppressNext)
    else $error("inhibit lasted past one instruction");
  a_clk_flip: assert property (acc |=> unitClkOut == $past(flipped))
    else $error("unit clock bits wrong");
  a_ovf_set: assert property (acc && stackAddress == 4'hf && instr.clkBits[1] && !instr.clkBits[2]
    && !instr.stackClear |=> stackOverflow) else $error("overflow not flagged");
  a_ovf_sticky: assert property (stackOverflow && !overflowClear |=> stackOverflow)
    else $error("overflow dropped without clear");
  a_irq_blocked: assert property (live && !irqInService && calm |=> !irqInService)
    else $error("interrupt entered without enabled request");
  a_pend_shown: assert property (live && !irqInService && !instrValid && |(ringIrqReq & portEnable)
    |=> irqPending) else $error("pending status missing");
  a_irq_entry: assert property ($rose(irqInService) |-> instrPtr == `MSBU_IRQ_VECTOR && !irqPending)
    else $error("interrupt entry state wrong");
  a_restore: assert property (irqInService && irqReturn |=> restoreStrobe && !irqInService
    && instrPtr == savedState.ptr) else $error("return did not restore");
endmodule // microsequencer_branch_unit_properties

bind microsequencer_branch_unit microsequencer_branch_unit_properties chk (
  .sys_clk, .resetn, .instrValid, .instr, .conditions, .unitClkIn, .unitClkOut, .ringIrqReq,
  .portEnable, .irqReturn, .overflowClear, .instrPtr, .stackAddress, .suppressNext, .savedState,
  .restoreStrobe, .irqInService, .irqPending, .stackOverflow
);

// *** sim/ring_port_model.sv ***
/*
 * Ring port partner: holds interrupt requests, sends the overflow clear
 * command and reads back the saved machine state.
 * Assumes the sequencer clock and raw reset.
 */
module ring_port_model
  import msbu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // bench commands
  input wire logic [7:0] raise,
  input wire logic clearCmd,
  // sequencer side
  input wire logic irqInService,
  input wire saved_state_s savedState,
  output logic [7:0] ringIrqReq,
  output logic overflowClear,
  output logic [15:0] readBack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // ring port state
  logic [7:0] req_q, req_d;
  logic clr_q, clr_d;
  logic [15:0] rb_q, rb_d;

  // a request stays up until the sequencer services it
  always_comb begin
    req_d = irqInService ? 8'h00 : (req_q | raise);
    clr_d = clearCmd;
    rb_d = irqInService ? savedState.machState : rb_q;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= 8'h00;
      clr_q <= 1'b0;
      rb_q <= 16'h0000;
    end else begin
      req_q <= req_d;
      clr_q <= clr_d;
      rb_q <= rb_d;
    end
  end
  assign ringIrqReq = req_q;
  assign overflowClear = clr_q;
  assign readBack = rb_q;
endmodule // ring_port_model

// *** sim/tb_microsequencer_branch_unit.sv ***
/*
 * Self-checking bench for the sequencer: source tables, inhibit, branch
 * and unit clocks, stack overflow, interrupts.
 * Assumes the ring port model and the bound checker.
 */
`include "msbu_defs.svh"

module tb_microsequencer_branch_unit import msbu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // signals
  logic sys_clk = 1'b0, resetn = 1'b0, instrValid = 1'b0, clearCmd = 1'b0;
  logic irqActivate = 1'b0, irqDeactivate = 1'b0, irqReturn = 1'b0;
  instr_s instr = '0, ins, alt;
  logic [15:0] xbarIn = 16'h0000, machStateIn = 16'h0000, operandReg, readBack, x, m;
  logic [3:0] conditions = 4'h0, stackAddress, c;
  logic [7:0] unitClkIn = 8'h00, portEnable = 8'h00, raise = 8'h00, unitClkOut, ringIrqReq, u;
  logic [11:0] instrPtr, stackTop, expPtr, expTop, opnd, k;
  logic suppressNext, restoreStrobe, irqInService, irqPending, stackOverflow, overflowClear;
  saved_state_s savedState;
  integer seed = 86, mismatches = 0, checksDone = 0, n, s;

  always #10 sys_clk = ~sys_clk;

  microsequencer_branch_unit uut (
    .sys_clk, .resetn, .instrValid, .instr, .xbarIn, .conditions, .unitClkIn, .unitClkOut,
    .ringIrqReq, .portEnable, .irqActivate, .irqDeactivate, .irqReturn, .machStateIn,
    .overflowClear, .instrPtr, .stackTop, .stackAddress, .operandReg, .suppressNext,
    .savedState, .restoreStrobe, .irqInService, .irqPending, .stackOverflow
  );
  ring_port_model ports (
    .sys_clk, .resetn, .raise, .clearCmd, .irqInService, .savedState, .ringIrqReq,
    .overflowClear, .readBack
  );

  // ==========================================
  // helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a spent bound counts as a mismatch and ends the run
  task automatic bail(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // one instruction with the staged operand, conditions and unit clocks
  task automatic run();
    @(posedge sys_clk);
    instr <= ins;
    instrValid <= 1'b1;
    xbarIn <= x;
    conditions <= c;
    unitClkIn <= u;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    #1;
  endtask

  // stack code n picks the same sum as jump code n+1
  function automatic logic [11:0] jt(input logic [2:0] src, input logic [11:0] p, q, a, t);
    case (src)
      3'h0: return t;
      3'h1: return p + q;
      3'h2: return q + a;
      3'h3: return q;
      3'h4: return t + a;
      3'h5: return p + a;
      3'h6: return a + a;
      default: return a;
    endcase
  endfunction

  // ==========================================
  // main sequence
  initial begin
    x = 16'h0000;
    c = 4'h0;
    u = 8'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    chk("instrPtr", instrPtr, 12'h000);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    expPtr = 12'h000;
    // every jump source and every stack source but STK_NONE
    for (s = 0; s < 8; s++) begin
      ins = '0;
      ins.clkBits = 5'h01;
      ins.stackWrite = 1'b1;
      ins.stackSrc = STK_K;
      ins.constant = $random(seed);
      x = $random(seed);
      opnd = x[11:0];
      expTop = ins.constant;
      run();
      expPtr++;
      chk("operandReg", operandReg, x);
      k = $random(seed);
      ins = '0;
      if (s < 7) begin
        ins.stackWrite = 1'b1;
        ins.stackSrc = stack_src_e'(s[2:0]);
        ins.constant = k;
        expTop = jt(s[2:0] + 3'h1, expPtr, k, opnd, expTop);
        run();
        expPtr++;
      end
      chk("stackTop", stackTop, expTop);
      ins = '0;
      ins.jumpEn = 1'b1;
      ins.jumpSrc = jump_src_e'(s[2:0]);
      ins.constant = ~k;
      expPtr = jt(s[2:0], expPtr, ~k, opnd, expTop);
      run();
      chk("instrPtr", instrPtr, expPtr);
    end
    $display("test sources finished");
    // inhibit after a taken jump, then after a fall-through
    for (s = 0; s < 2; s++) begin
      ins = '0;
      ins.jumpEn = (s == 0);
      ins.jumpSrc = JMP_K;
      ins.constant = 12'h0a5;
      ins.clkBits = s ? 5'h10 : 5'h08;
      alt = '0;
      alt.jumpEn = 1'b1;
      alt.constant = 12'h3c3;
      @(posedge sys_clk);
      instr <= ins;
      instrValid <= 1'b1;
      @(posedge sys_clk);
      instr <= alt;
      #1;
      chk("suppressNext", suppressNext, 1'b1);
      @(posedge sys_clk);
      instrValid <= 1'b0;
      #1;
      expPtr = (s == 0 ? 12'h0a5 : expPtr + 12'h001) + 12'h001;
      chk("instrPtr", instrPtr, expPtr);
    end
    $display("test inhibit finished");
    // random conditional branches and unit clock flips
    for (n = 0; n < 24; n++) begin
      ins = '0;
      ins.jumpEn = 1'b1;
      ins.jumpSrc = JMP_K;
      ins.constant = $random(seed);
      ins.condMask = $random(seed);
      ins.condClkEn = 1'b1;
      ins.unitSelectField = n[2:0];
      c = $random(seed);
      u = $random(seed);
      run();
      expPtr = (ins.condMask == 4'h0 || |(ins.condMask & c)) ? ins.constant : expPtr + 12'h001;
      chk("instrPtr", instrPtr, expPtr);
      chk("unitClkOut", unitClkOut, u ^ (|(ins.condMask & c) ? 8'h01 << n[2:0] : 8'h00));
    end
    $display("test conditions finished");
    // sixteen pushes overflow, a pop leaves the flag up
    for (n = 1; n <= 17; n++) begin
      ins = '0;
      ins.clkBits = (n == 17) ? 5'h04 : 5'h02;
      run();
      chk("stackAddress", stackAddress, n == 17 ? 4'he : (n > 15 ? 4'hf : n[3:0]));
      chk("stackOverflow", stackOverflow, n >= 16);
    end
    repeat (3) @(posedge sys_clk);
    #1;
    chk("stackOverflow", stackOverflow, 1'b1);
    @(posedge sys_clk);
    clearCmd <= 1'b1;
    @(posedge sys_clk);
    clearCmd <= 1'b0;
    for (n = 0; n < 8 && stackOverflow !== 1'b0; n++) @(posedge sys_clk);
    #1;
    bail(stackOverflow === 1'b0);
    ins = '0;
    ins.stackClear = 1'b1;
    ins.clkBits = 5'h02;
    run();
    chk("stackAddress", stackAddress, 4'h0);
    expPtr = expPtr + 12'h012;
    $display("test stack finished");
    // blocked port, then deactivated system, then a taken interrupt
    @(posedge sys_clk);
    raise <= 8'h08;
    irqActivate <= 1'b1;
    @(posedge sys_clk);
    raise <= 8'h00;
    irqActivate <= 1'b0;
    ins = '0;
    run();
    chk("irqPending", irqPending, 1'b0);
    @(posedge sys_clk);
    irqDeactivate <= 1'b1;
    portEnable <= 8'h08;
    @(posedge sys_clk);
    irqDeactivate <= 1'b0;
    run();
    expPtr = expPtr + 12'h002;
    chk("irqInService", irqInService, 1'b0);
    chk("irqPending", irqPending, 1'b1);
    chk("instrPtr", instrPtr, expPtr);
    m = $random(seed);
    @(posedge sys_clk);
    irqActivate <= 1'b1;
    machStateIn <= m;
    @(posedge sys_clk);
    irqActivate <= 1'b0;
    run();
    for (n = 0; n < 8 && irqInService !== 1'b1; n++) @(posedge sys_clk);
    #1;
    bail(irqInService === 1'b1);
    chk("instrPtr", instrPtr, `MSBU_IRQ_VECTOR);
    chk("savedPtr", savedState.ptr, expPtr);
    @(posedge sys_clk);
    #1;
    chk("readBack", readBack, m);
    @(posedge sys_clk);
    irqReturn <= 1'b1;
    @(posedge sys_clk);
    irqReturn <= 1'b0;
    #1;
    chk("restoreStrobe", restoreStrobe, 1'b1);
    chk("instrPtr", instrPtr, expPtr);
    $display("test interrupt finished");
    tally_and_finish();
  end
endmodule // tb_microsequencer_branch_unit
